/* hdl/bacd_top.sv */
// Bus area configuration register and upper address map decoder.
// Assumes an AXI4-Lite master and a CPU address bus on the same clock (125 MHz).
// Summary of operation
// - 0x24000000-0x25FFFFFF decodes to area 2 cache-through.
// - 0x26000000-0x27FFFFFF decodes to area 3 cache-through.
// - 32 MB from 0x28000000 decodes to area 4 cache-through.
// - Decode 160 MB purge space and 512 MB address-array space.
// - Decode 4 KB data-array space at 0xC0000000.
// - 4 KB windows at FFFF0000 and FFFF8000 are SDRAM mode settings.
// - Area 2 synchronous DRAM always uses auto-precharge.
// - Area 3 synchronous DRAM supports bank-active operation.
// - Bits 15 and 10 always read zero.
// - Bits 14:13 give area 4 long wait when its wait field is 11.
// - Bit 12 set makes area 2 little-endian.
// - Bit 11 set makes area 0 burst ROM.
// - Bits 9:8 give area 2/3 long wait when wait field is 11.
// - Bits 7:6 give area 1 long wait, computed for a range check only; no port carries it.
// - Bits 5:4 give area 0 long wait, computed for a range check only; no port carries it.
// - Bit 3 set makes area 4 little-endian.
// - Bits 2:0 choose memory type of areas 2 and 3.
// - 16-bit register, reset 0x03F0, at 0xFFFFFFE0.
// - Writes need key 0xA55A in upper half; reads return zero there.
// - Three-bit code maps to 3,4,5,6,8,10,12,14 waits.
module bacd_top
  import bacd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AXI4-Lite write address and data
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // CPU access to decode
  input  wire logic [31:0] cpu_addr,
  input  wire logic [1:0]  cpu_size,
  input  wire logic [31:0] cpu_wdata,
  // Decode results, registered
  output logic [3:0]       space_code,
  output logic             cache_through,
  output logic             sdram_mode_set,
  output logic             area_is_sdram,
  output logic             area_is_dram,
  output logic             auto_precharge,
  output logic             bank_active_ok,
  output logic             burst_rom,
  output logic [3:0]       wait_cycles,
  output logic             long_wait_active,
  output logic             mem_type_illegal,
  output logic [31:0]      swapped_wdata
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] wsel;   // 1:0 a0,3:2 a1,5:4 a2,7:6 a3,9:8 a4,14:11 third bits
    bacd_bus_t   wst;
    bacd_bus_t   rst;
    logic        aw_got;
    logic        w_got;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  bresp;
    logic [3:0]  space;
    logic        thru;
    logic        mode;
    logic        sdr;
    logic        dram;
    logic        apre;
    logic        bact;
    logic        brom;
    logic [3:0]  waits;
    logic        lw;
    logic        mt_bad;
    logic        swap;
  } bacd_state_t;
  bacd_state_t st;
  bacd_state_t next_st;

  function automatic logic [3:0] lw_count(input logic [2:0] code);
    logic [3:0] r;
    r = 4'h3;
    unique case (code)
      3'h0: r = 4'h3;
      3'h1: r = 4'h4;
      3'h2: r = 4'h5;
      3'h3: r = 4'h6;
      3'h4: r = 4'h8;
      3'h5: r = 4'hA;
      3'h6: r = 4'hC;
      3'h7: r = 4'hE;
    endcase
    return r;
  endfunction : lw_count

  function automatic logic in_win(input logic [31:0] a, input logic [31:0] b,
                                  input logic [31:0] m);
    return (a & m) == b;
  endfunction : in_win

  logic        wr_fire;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic        key_ok;
  logic [1:0]  ws;
  logic        w3;
  logic [1:0]  lw2;

  // ==========================================================================
  // Bus and decode next state
  always_comb begin
    next_st = st;
    wr_addr = st.aw_got ? st.awaddr : s_axi_awaddr;
    wr_data = st.w_got ? st.wdata : s_axi_wdata;
    wr_fire = (st.aw_got || s_axi_awvalid) && (st.w_got || s_axi_wvalid)
              && st.wst == BACD_ST_IDLE;
    // key in upper half guards writes
    key_ok = wr_data[31:16] == BACD_WR_KEY && (st.w_got ? st.wstrb : s_axi_wstrb) == 4'hF;
    ws = 2'h0;
    w3 = 1'b0;
    lw2 = 2'h0;
    if (st.wst == BACD_ST_IDLE) begin
      if (s_axi_awvalid && !st.aw_got) begin
        next_st.aw_got = 1'b1;
        next_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.w_got) begin
        next_st.w_got = 1'b1;
        next_st.wdata = s_axi_wdata;
        next_st.wstrb = s_axi_wstrb;
      end
      if (wr_fire) begin
        next_st.aw_got = 1'b0;
        next_st.w_got = 1'b0;
        next_st.wst = BACD_ST_RESP;
        next_st.bresp = BACD_RESP_OKAY;
        if (wr_addr == BACD_CTRL1_ADDR) begin
          if (key_ok) next_st.ctrl = wr_data[15:0] & BACD_CTRL1_WMASK;
        end else if (wr_addr == BACD_WAITSEL_ADDR) begin
          if (key_ok) next_st.wsel = wr_data[15:0];
        end else begin
          next_st.bresp = BACD_RESP_SLVERR;
        end
      end
    end else if (s_axi_bready) begin
      next_st.wst = BACD_ST_IDLE;
    end
    // read view with zero upper half
    if (st.rst == BACD_ST_IDLE) begin
      if (s_axi_arvalid) begin
        next_st.rst = BACD_ST_RESP;
        next_st.rresp = BACD_RESP_OKAY;
        next_st.rdata = 32'h00000000;
        if (s_axi_araddr == BACD_CTRL1_ADDR) next_st.rdata = {16'h0000, st.ctrl};
        else if (s_axi_araddr == BACD_WAITSEL_ADDR) next_st.rdata = {16'h0000, st.wsel};
        else next_st.rresp = BACD_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      next_st.rst = BACD_ST_IDLE;
    end
    next_st.space = BACD_SP_NONE;
    if (in_win(cpu_addr, BACD_A2_BASE, BACD_M32M)) next_st.space = BACD_SP_A2;
    else if (in_win(cpu_addr, BACD_A3_BASE, BACD_M32M)) next_st.space = BACD_SP_A3;
    else if (in_win(cpu_addr, BACD_A4_BASE, BACD_M32M)) next_st.space = BACD_SP_A4;
    else if (cpu_addr >= BACD_PURGE_BASE && cpu_addr <= BACD_PURGE_END)
      next_st.space = BACD_SP_PURGE;
    else if (in_win(cpu_addr, BACD_ADDR_BASE, BACD_M512M)) next_st.space = BACD_SP_ADDR;
    else if (in_win(cpu_addr, BACD_DATA_BASE, BACD_M4K)) next_st.space = BACD_SP_DATA;
    else if (in_win(cpu_addr, BACD_MODE0_BASE, BACD_M4K)
             || in_win(cpu_addr, BACD_MODE1_BASE, BACD_M4K)) next_st.space = BACD_SP_MODE;
    next_st.thru = next_st.space inside {BACD_SP_A2, BACD_SP_A3, BACD_SP_A4};
    next_st.mode = next_st.space == BACD_SP_MODE;
    // memory type of areas 2 and 3
    next_st.mt_bad = !(st.ctrl[BACD_MT_HI:0] inside {BACD_MT_ORD, BACD_MT_A3_SDR,
                       BACD_MT_A3_DRAM, BACD_MT_A2_SDR, BACD_MT_BOTH});
    next_st.sdr = 1'b0;
    next_st.dram = 1'b0;
    if (next_st.space == BACD_SP_A2) begin
      next_st.sdr = st.ctrl[BACD_MT_HI:0] inside {BACD_MT_A2_SDR, BACD_MT_BOTH};
    end else if (next_st.space == BACD_SP_A3) begin
      next_st.sdr = st.ctrl[BACD_MT_HI:0] inside {BACD_MT_A3_SDR, BACD_MT_BOTH};
      next_st.dram = st.ctrl[BACD_MT_HI:0] == BACD_MT_A3_DRAM;
    end
    next_st.apre = next_st.sdr && next_st.space == BACD_SP_A2;
    // area 3 SDRAM may keep banks open
    next_st.bact = next_st.sdr && next_st.space == BACD_SP_A3;
    // burst ROM flag for area 0
    next_st.brom = st.ctrl[BACD_BROM];
    // long wait selection for decoded area
    if (next_st.space == BACD_SP_A2) begin
      ws = st.wsel[BACD_WS_A2 +: 2];
      w3 = st.wsel[BACD_W3_A23];
      lw2 = st.ctrl[BACD_AHLW_HI:BACD_AHLW_LO];
    end else if (next_st.space == BACD_SP_A3) begin
      ws = st.wsel[BACD_WS_A3 +: 2];
      w3 = st.wsel[BACD_W3_A23];
      lw2 = st.ctrl[BACD_AHLW_HI:BACD_AHLW_LO];
    end else if (next_st.space == BACD_SP_A4) begin
      ws = st.wsel[BACD_WS_A4 +: 2];
      w3 = st.wsel[BACD_W3_A4];
      lw2 = st.ctrl[BACD_A4LW_HI:BACD_A4LW_LO];
    end
    next_st.lw = ws == BACD_LONG_WAIT && next_st.thru && !next_st.sdr && !next_st.dram;
    next_st.waits = next_st.lw ? lw_count({w3, lw2}) : 4'h0;
    next_st.swap = (next_st.space == BACD_SP_A2 && st.ctrl[BACD_A2_END])
                   || (next_st.space == BACD_SP_A4 && st.ctrl[BACD_A4_END]);
  end

  // Single register stage for all state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.ctrl <= BACD_CTRL1_RST;
      st.wsel <= BACD_WAITSEL_RST;
      st.wst <= BACD_ST_IDLE;
      st.rst <= BACD_ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Little-endian lane reversal, one cycle like the decode
  bacd_lane_swap u_swap (
    .clk      (clk),
    .rst_n    (rst_n),
    .swap_en  (next_st.swap),
    .size     (cpu_size),
    .data_in  (cpu_wdata),
    .data_out (swapped_wdata)
  );

  // Areas 0 and 1 long waits are computed for the range check only; no port carries them
  logic [3:0] a0_waits;
  logic [3:0] a1_waits;
  assign a0_waits = lw_count({st.wsel[BACD_W3_A0], st.ctrl[BACD_A0LW_HI:BACD_A0LW_LO]});
  assign a1_waits = lw_count({st.wsel[BACD_W3_A1], st.ctrl[BACD_A1LW_HI:BACD_A1LW_LO]});

  // Handshake and decode outputs
  assign s_axi_awready = st.wst == BACD_ST_IDLE && !st.aw_got;
  assign s_axi_wready  = st.wst == BACD_ST_IDLE && !st.w_got;
  assign s_axi_bvalid  = st.wst == BACD_ST_RESP;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.rst == BACD_ST_IDLE;
  assign s_axi_rvalid  = st.rst == BACD_ST_RESP;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign space_code       = st.space;
  assign cache_through    = st.thru;
  assign sdram_mode_set   = st.mode;
  assign area_is_sdram    = st.sdr;
  assign area_is_dram     = st.dram;
  assign auto_precharge   = st.apre;
  assign bank_active_ok   = st.bact;
  assign burst_rom        = st.brom;
  assign wait_cycles      = st.waits;
  assign long_wait_active = st.lw;
  assign mem_type_illegal = st.mt_bad;

  // ==========================================================================
  // Checks
  a2_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_addr[31:25] == 7'h12) |=> space_code == BACD_SP_A2)
    else $error("area 2 window not decoded");
  a3_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_addr[31:25] == 7'h13) |=> space_code == BACD_SP_A3)
    else $error("area 3 window not decoded");
  a4_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_addr[31:25] == 7'h14) |=> space_code == BACD_SP_A4 && cache_through)
    else $error("area 4 window not decoded");
  mode_win_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_addr[31:12] == 20'hFFFF0) |=> sdram_mode_set)
    else $error("mode window missed");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  ctrl_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st.ctrl & ~BACD_CTRL1_WMASK) == 16'h0000)
    else $error("reserved control bits set");
  area01_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    a0_waits >= 4'h3 && a0_waits <= 4'hE && a1_waits >= 4'h3 && a1_waits <= 4'hE)
    else $error("area 0 or 1 long wait out of range");
  precharge_a: assert property (@(posedge clk) disable iff (!rst_n)
    auto_precharge |-> !bank_active_ok && space_code == BACD_SP_A2)
    else $error("area 2 bank kept open");
  key_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_fire && !key_ok) |=> $stable(st.ctrl))
    else $error("unkeyed write changed register");
  wait_max_a: assert property (@(posedge clk) disable iff (!rst_n)
    long_wait_active |-> wait_cycles >= 4'h3 && wait_cycles <= 4'hE)
    else $error("long wait out of range");
  cov_keyed_wr: cover property (@(posedge clk) wr_fire && key_ok);
  cov_swap: cover property (@(posedge clk) st.swap);
  cov_lw: cover property (@(posedge clk) long_wait_active);
endmodule : bacd_top

/* hdl/bacd_pkg.sv */
// Constants, field layouts and address windows for the bus area configuration and decode block.
// Assumes a 32-bit AXI4-Lite register port and a 32-bit CPU address for the area decoder.
package bacd_pkg;
  // ==========================================================================
  // Register layout
  localparam logic [31:0] BACD_CTRL1_ADDR  = 32'hFFFFFFE0;  // Control register, 32-bit view
  localparam logic [31:0] BACD_WAITSEL_ADDR = 32'hFFFFFFD0; // Wait-select and third-bit register
  localparam logic [15:0] BACD_CTRL1_RST   = 16'h03F0;
  localparam logic [15:0] BACD_CTRL1_WMASK = 16'h7BFF;      // Bits 15 and 10 read as zero
  localparam logic [15:0] BACD_WR_KEY      = 16'hA55A;
  localparam logic [15:0] BACD_WAITSEL_RST = 16'h0000;
  localparam int BACD_A4LW_HI = 14;
  localparam int BACD_A4LW_LO = 13;
  localparam int BACD_A2_END  = 12;
  localparam int BACD_BROM    = 11;
  localparam int BACD_AHLW_HI = 9;
  localparam int BACD_AHLW_LO = 8;
  localparam int BACD_A1LW_HI = 7;
  localparam int BACD_A1LW_LO = 6;
  localparam int BACD_A0LW_HI = 5;
  localparam int BACD_A0LW_LO = 4;
  localparam int BACD_A4_END  = 3;
  localparam int BACD_MT_HI   = 2;
  localparam logic [1:0] BACD_LONG_WAIT = 2'h3;
  // Wait-select layout: low bit of each two-bit wait field, then third long-wait bits
  localparam int BACD_WS_A2  = 4;
  localparam int BACD_WS_A3  = 6;
  localparam int BACD_WS_A4  = 8;
  localparam int BACD_W3_A23 = 11;
  localparam int BACD_W3_A4  = 12;
  localparam int BACD_W3_A0  = 13;
  localparam int BACD_W3_A1  = 14;
  // Access size codes seen by the lane reversal
  localparam logic [1:0] BACD_SZ_WORD = 2'h1;
  localparam logic [1:0] BACD_SZ_LONG = 2'h2;
  localparam logic [1:0] BACD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] BACD_RESP_SLVERR = 2'h2;
  // ==========================================================================
  // Memory type codes
  localparam logic [2:0] BACD_MT_ORD     = 3'h0;
  localparam logic [2:0] BACD_MT_A3_SDR  = 3'h1;
  localparam logic [2:0] BACD_MT_A3_DRAM = 3'h2;
  localparam logic [2:0] BACD_MT_A2_SDR  = 3'h4;
  localparam logic [2:0] BACD_MT_BOTH    = 3'h5;
  // ==========================================================================
  // Address windows: base and mask of bits that must match; purge uses base and end
  localparam logic [31:0] BACD_A2_BASE   = 32'h24000000;
  localparam logic [31:0] BACD_A3_BASE   = 32'h26000000;
  localparam logic [31:0] BACD_A4_BASE   = 32'h28000000;
  localparam logic [31:0] BACD_M32M      = 32'hFE000000;
  localparam logic [31:0] BACD_PURGE_BASE = 32'h40000000;
  localparam logic [31:0] BACD_PURGE_END  = 32'h49FFFFFF;
  localparam logic [31:0] BACD_ADDR_BASE = 32'h60000000;
  localparam logic [31:0] BACD_M512M     = 32'hE0000000;
  localparam logic [31:0] BACD_DATA_BASE = 32'hC0000000;
  localparam logic [31:0] BACD_M4K       = 32'hFFFFF000;
  localparam logic [31:0] BACD_MODE0_BASE = 32'hFFFF0000;
  localparam logic [31:0] BACD_MODE1_BASE = 32'hFFFF8000;
  // Space codes
  typedef enum logic [3:0] {
    BACD_SP_NONE  = 4'h0,
    BACD_SP_A2    = 4'h1,
    BACD_SP_A3    = 4'h2,
    BACD_SP_A4    = 4'h3,
    BACD_SP_PURGE = 4'h4,
    BACD_SP_ADDR  = 4'h5,
    BACD_SP_DATA  = 4'h6,
    BACD_SP_MODE  = 4'h7
  } bacd_space_t;
  typedef enum logic [1:0] {
    BACD_ST_IDLE = 2'b00,
    BACD_ST_RESP = 2'b01
  } bacd_bus_t;
endpackage : bacd_pkg

/* hdl/bacd_lane_swap.sv */
// Byte lane reversal for little-endian areas.
// Assumes size code 0 byte, 1 word, 2 longword; registered output, one cycle latency.
module bacd_lane_swap
  import bacd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request
  input  wire logic        swap_en,
  input  wire logic [1:0]  size,
  input  wire logic [31:0] data_in,
  // Result
  output logic      [31:0] data_out
);
  // ==========================================================================
  // Lane reversal
  typedef struct packed {
    logic [31:0] data;
  } bacd_swap_t;
  bacd_swap_t st;
  bacd_swap_t next_st;

  always_comb begin
    next_st = st;
    next_st.data = data_in;
    if (swap_en && size == BACD_SZ_WORD) begin
      next_st.data = {16'h0000, data_in[7:0], data_in[15:8]};
    end else if (swap_en && size == BACD_SZ_LONG) begin
      next_st.data = {data_in[7:0], data_in[15:8], data_in[23:16], data_in[31:24]};
    end
  end

  // Byte accesses pass through unchanged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign data_out = st.data;
endmodule : bacd_lane_swap

/* verification/bacd_cpu_model.sv */
// Behavioural CPU access source that feeds the area decoder.
// Assumes the decoder samples its access inputs as levels on clk.
module bacd_cpu_model (
  // Clock
  input  wire logic        clk,
  // Access towards the decoder
  output logic      [31:0] cpu_addr,
  output logic      [1:0]  cpu_size,
  output logic      [31:0] cpu_wdata,
  // Accesses withheld by the model
  output logic             refused
);
  timeunit 1ns;
  timeprecision 1ps;
  logic init_done;
  // ==========================================================================
  // Access legality
  function automatic logic legal(input logic [31:0] a);
    if (!init_done) return (a[31:29] <= 3'h1) && (a[28:25] == 4'h0);
    return (a < 32'h0A000000) || (a >= 32'h20000000 && a < 32'h2A000000) ||
           (a >= 32'h40000000 && a < 32'h4A000000) || (a[31:29] == 3'h3) ||
           (a[31:12] == 20'hC0000) || (a[31:12] == 20'hFFFF0) ||
           (a[31:12] == 20'hFFFF8) || (a >= 32'hFFFFFC00);
  endfunction : legal
  // Idle values before the first access
  initial begin
    cpu_addr  = 32'h00000000;
    cpu_size  = 2'h2;
    cpu_wdata = 32'h00000000;
    refused   = 1'b0;
    init_done = 1'b0;
  end
  // Setup finished, the wider map may now be used
  task automatic mark_init();
    init_done = 1'b1;
  endtask : mark_init
  // One access held for hold cycles; a long hold models a slow CPU
  task automatic issue(input logic [31:0] a, input logic [1:0] s, input logic [31:0] d,
                       input int hold);
    @(posedge clk);
    if (legal(a)) begin
      cpu_addr  <= a;
      cpu_size  <= s;
      cpu_wdata <= d;
    end else begin
      refused <= 1'b1;
    end
    repeat (hold) @(posedge clk);
  endtask : issue
endmodule : bacd_cpu_model

/* verification/testbench.sv */
// Self-checking bench for the bus area configuration and decode block.
// Assumes AXI4-Lite register access and the CPU access model beside it.
module testbench
  import bacd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, rd, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cache_through, sdram_mode_set, area_is_sdram, area_is_dram;
  logic auto_precharge, bank_active_ok, burst_rom, long_wait_active, mem_type_illegal, refused;
  logic [1:0] s_axi_bresp, s_axi_rresp, cpu_size, resp;
  logic [31:0] cpu_addr, cpu_wdata, swapped_wdata;
  logic [3:0] space_code, wait_cycles, s_axi_wstrb = 4'hF;
  int n_mismatch = 0, num_checks = 0, cycles = 0;
  // ==========================================================================
  // Clock, timeout and instances
  always #4 clk = ~clk;
  // Cut a hang short well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  bacd_cpu_model cpu (.clk(clk), .cpu_addr(cpu_addr), .cpu_size(cpu_size),
                      .cpu_wdata(cpu_wdata), .refused(refused));
  bacd_top dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cpu_addr(cpu_addr), .cpu_size(cpu_size),
    .cpu_wdata(cpu_wdata), .space_code(space_code), .cache_through(cache_through),
    .sdram_mode_set(sdram_mode_set), .area_is_sdram(area_is_sdram),
    .area_is_dram(area_is_dram), .auto_precharge(auto_precharge),
    .bank_active_ok(bank_active_ok), .burst_rom(burst_rom), .wait_cycles(wait_cycles),
    .long_wait_active(long_wait_active), .mem_type_illegal(mem_type_illegal),
    .swapped_wdata(swapped_wdata));
  // ==========================================================================
  // Compare, reset and bus tasks
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // Two clock cycles of reset so every test starts from power-on values
  task automatic fresh();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : fresh
  // Ready is looked at on the falling edge, so the value is the one the next rising edge sees
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    logic ta, tw, b_ok;
    b_ok = 1'b0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b_ok) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      b_ok = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (b_ok) s_axi_bready <= 1'b0;
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a);
    logic ta, r_ok;
    r_ok = 1'b0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!r_ok) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      r_ok = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (r_ok) s_axi_rready <= 1'b0;
    end
  endtask : axi_rd
  task automatic wr_ctrl(input logic [15:0] v);
    axi_wr(BACD_CTRL1_ADDR, {BACD_WR_KEY, v});
  endtask : wr_ctrl
  // Access through the CPU model, then sample once settled
  task automatic acc(input logic [31:0] a, input logic [1:0] s, input logic [31:0] d);
    cpu.issue(a, s, d, 3);
    @(negedge clk);
  endtask : acc
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    axi_rd(BACD_CTRL1_ADDR);
    chk_word(rd, 32'h000003F0);
    chk_word({30'h0, resp}, {30'h0, BACD_RESP_OKAY});
    axi_wr(BACD_CTRL1_ADDR, 32'h0000FFFF);
    chk_word({30'h0, resp}, {30'h0, BACD_RESP_OKAY});
    axi_rd(BACD_CTRL1_ADDR);
    chk_word(rd, 32'h000003F0);
    // keyed write with partial strobes is ignored
    s_axi_wstrb <= 4'h3;
    wr_ctrl(16'h0000);
    s_axi_wstrb <= 4'hF;
    axi_rd(BACD_CTRL1_ADDR);
    chk_word(rd, 32'h000003F0);
    wr_ctrl(16'hFFFF);
    axi_rd(BACD_CTRL1_ADDR);
    chk_word(rd, 32'h00007BFF);
    axi_rd(32'hFFFFFFC8);
    chk_word({rd[31:2], resp}, {30'h0, BACD_RESP_SLVERR});
    fresh();
    $display("test regs done");
  endtask : t_regs
  task automatic t_map();
    logic [31:0] ad [10] = '{32'h24000000, 32'h25FFFFFF, 32'h26000000, 32'h28000000,
      32'h29FFFFFF, 32'h49FFFFFF, 32'h7FFFFFFF, 32'hC0000FFF, 32'hFFFF0000, 32'hFFFF8FFF};
    logic [3:0] sc [10] = '{4'h1, 4'h1, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h7};
    // only area 0 until the register is set up
    wr_ctrl(16'h03F0);
    cpu.mark_init();
    for (int i = 0; i < 10; i++) begin
      cpu.issue(ad[i], 2'h2, 32'h0, (i % 2) ? 6 : 3);
      @(negedge clk);
      chk_word({28'h0, space_code}, {28'h0, sc[i]});
      chk_bit(cache_through, sc[i] inside {4'h1, 4'h2, 4'h3});
      chk_bit(sdram_mode_set, sc[i] == 4'h7);
    end
    $display("test map done");
  endtask : t_map
  task automatic t_wait();
    logic [31:0] wt [8] = '{32'h3, 32'h4, 32'h5, 32'h6, 32'h8, 32'hA, 32'hC, 32'hE};
    for (int i = 0; i < 8; i++) begin
      axi_wr(BACD_WAITSEL_ADDR, {BACD_WR_KEY, 16'h0330 | (16'(i / 4) * 16'h1800)});
      // type, endian and burst fields are written as zero; only long-wait fields 14:13 and 9:8 vary
      wr_ctrl(16'(i % 4) * 16'h2100);
      acc(BACD_A4_BASE, 2'h2, 32'h0);
      chk_word({28'h0, wait_cycles}, wt[i]);
      chk_bit(long_wait_active, 1'b1);
      acc(BACD_A2_BASE, 2'h2, 32'h0);
      chk_word({28'h0, wait_cycles}, wt[i]);
    end
    axi_wr(BACD_WAITSEL_ADDR, {BACD_WR_KEY, 16'h0000});
    acc(BACD_A4_BASE, 2'h2, 32'h0);
    chk_word({28'h0, wait_cycles}, 32'h0);
    chk_bit(long_wait_active, 1'b0);
    $display("test wait done");
  endtask : t_wait
  task automatic t_types();
    logic [2:0] mt [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3};
    for (int i = 0; i < 6; i++) begin
      fresh();
      wr_ctrl(16'h03F0 | 16'(mt[i]));
      acc(BACD_A2_BASE, 2'h2, 32'h0);
      chk_bit(area_is_sdram, mt[i] inside {3'h4, 3'h5});
      chk_bit(auto_precharge, mt[i] inside {3'h4, 3'h5});
      chk_bit(mem_type_illegal, mt[i] == 3'h3);
      acc(BACD_A3_BASE, 2'h2, 32'h0);
      chk_bit(area_is_sdram, mt[i] inside {3'h1, 3'h5});
      chk_bit(area_is_dram, mt[i] == 3'h2);
      chk_bit(bank_active_ok, mt[i] inside {3'h1, 3'h5});
    end
    $display("test types done");
  endtask : t_types
  task automatic t_endian();
    fresh();
    wr_ctrl(16'h1BF8);
    @(negedge clk);
    chk_bit(burst_rom, 1'b1);
    acc(BACD_A4_BASE, 2'h2, 32'h11223344);
    chk_word(swapped_wdata, 32'h44332211);
    acc(BACD_A2_BASE, 2'h2, 32'h11223344);
    chk_word(swapped_wdata, 32'h44332211);
    acc(BACD_A4_BASE, 2'h0, 32'h11223344);
    chk_word(swapped_wdata, 32'h11223344);
    acc(BACD_A2_BASE, 2'h1, 32'h11223344);
    chk_word(swapped_wdata, 32'h00004433);
    acc(BACD_A3_BASE, 2'h2, 32'h11223344);
    chk_word(swapped_wdata, 32'h11223344);
    fresh();
    // set up again before leaving area 0
    wr_ctrl(16'h03F0);
    acc(BACD_A2_BASE, 2'h2, 32'h11223344);
    chk_word(swapped_wdata, 32'h11223344);
    chk_bit(burst_rom, 1'b0);
    chk_bit(refused, 1'b0);
    $display("test endian done");
  endtask : t_endian
  // ==========================================================================
  // Verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    fresh();
    t_regs();
    t_map();
    t_wait();
    t_types();
    t_endian();
    final_report();
  end
endmodule : testbench
